// file: hdl/ifep_pkg.sv
/*
	Register map, bit positions, reset values and the bus carrier of the
	interrupt flag/enable/priority block.
	Assumes an 8-bit register port with one-cycle read and write strobes.
*/
`default_nettype none
package ifep_pkg;
	localparam int AW = 8;
	localparam int DW = 8;
	localparam int NUM_PREG_DEF = 5;
	localparam int NUM_PREG_MAX = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] ADDR_RESET_CTRL = 8'h00;
	localparam logic [AW-1:0] ADDR_INT_CTRL = 8'h01;
	localparam logic [AW-1:0] ADDR_EXT_CTRL = 8'h02;
	localparam logic [AW-1:0] ADDR_FLAG_BASE = 8'h08;
	localparam logic [AW-1:0] ADDR_ENA_BASE = 8'h10;
	localparam logic [AW-1:0] ADDR_PRIO_BASE = 8'h18;
	localparam logic [AW-1:0] ADDR_EVT_STAT = 8'h20;
	localparam logic [AW-1:0] ADDR_EVT_MASK = 8'h21;

	// ----------------------------------------------------------------
	// Bit positions
	// ----------------------------------------------------------------
	localparam int PLE_BIT = 7;
	localparam int GHE_BIT = 7;
	localparam int PLGE_BIT = 6;
	localparam int E2P_BIT = 7;
	localparam int E1P_BIT = 6;
	localparam int E2E_BIT = 4;
	localparam int E1E_BIT = 3;
	localparam int E2F_BIT = 1;
	localparam int E1F_BIT = 0;
	localparam int EV_HIGH = 0;
	localparam int EV_LOW = 1;
	localparam int EV_LINE1 = 2;
	localparam int EV_LINE2 = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic EXT_PRIO_RST = 1'b1;
	localparam logic [DW-1:0] PRIO_RST = 8'hFF;
	localparam logic [DW-1:0] ZERO_RST = 8'h00;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} ifep_bus_req_t;

	// Bank decode: eight registers per aligned group, n of them present
	function automatic logic ifep_in_bank(input logic [AW-1:0] a,
		input logic [AW-1:0] base, input int n);
		return (a[AW-1:3] == base[AW-1:3]) && (int'(a[2:0]) < n);
	endfunction
endpackage
`default_nettype wire

// file: hdl/ifep_flag_bank.sv
/*
	Sticky flag bank: hardware sets, software writes through a mask.
	Assumes set and write arrive synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module ifep_flag_bank
#(
	parameter int W = 8
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [W-1:0] hw_set,
	input wire logic sw_wr,
	input wire logic [W-1:0] sw_data,
	input wire logic [W-1:0] sw_mask,
	output logic [W-1:0] flags
);
	import ifep_pkg::*;

	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;

	always_comb
	begin
		flags_d = flags_q;
		if (sw_wr)
		begin
			flags_d = (flags_q & ~sw_mask) | (sw_data & sw_mask);
		end
		flags_d = flags_d | hw_set;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flags_q <= '0;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;
endmodule // ifep_flag_bank
`default_nettype wire

// file: hdl/ifep_req_router.sv
/*
	Combinational request router for peripheral and external sources.
	Assumes all inputs are register outputs of the parent.
*/
`timescale 1ns/10ps
`default_nettype none
module ifep_req_router
#(
	parameter int N = 40
)
(
	input wire logic [N-1:0] pflag,
	input wire logic [N-1:0] pena,
	input wire logic [N-1:0] pprio,
	input wire logic [1:0] eflag,
	input wire logic [1:0] eena,
	input wire logic [1:0] eprio,
	input wire logic ple,
	input wire logic ghe,
	input wire logic plge,
	output logic req_high,
	output logic req_low
);
	import ifep_pkg::*;

	logic [N-1:0] pact;
	logic [1:0] eact;

	assign pact = pflag & pena;
	assign eact = eflag & eena;

	always_comb
	begin
		if (ple)
		begin
			req_high = ghe & (|(pact & pprio) | |(eact & eprio));
			req_low = ghe & plge & (|(pact & ~pprio) | |(eact & ~eprio));
		end
		else
		begin
			req_high = ghe & (|eact | (plge & |pact));
			req_low = 1'b0;
		end
	end
endmodule // ifep_req_router
`default_nettype wire

// file: hdl/ifep_top.sv
/*
	Interrupt flag, enable and priority block with register port and
	event status/mask interrupt.
	Assumes source inputs and the register port are synchronous to
	clk_sys; peripheral events are one-cycle pulses.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ifep_top
#(
	parameter int NUM_PREG = ifep_pkg::NUM_PREG_DEF
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire ifep_pkg::ifep_bus_req_t bus_req,
	output logic [ifep_pkg::DW-1:0] rd_data,
	input wire logic [NUM_PREG*ifep_pkg::DW-1:0] periph_event,
	input wire logic ext_irq_line_one,
	input wire logic ext_irq_line_two,
	output logic irq_high,
	output logic irq_low,
	output logic sys_irq
);
	import ifep_pkg::*;

	localparam int NSRC = NUM_PREG * DW;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (NUM_PREG < 1 || NUM_PREG > NUM_PREG_MAX)
	begin : g_bad_preg
		$error("NUM_PREG out of range");
	end

	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic wr;
	logic rd;
	logic wr_rst;
	logic wr_ictl;
	logic wr_ext;
	logic wr_emask;
	logic rd_stat;
	logic ple_q;
	logic ghe_q;
	logic plge_q;
	logic [1:0] eprio_q;
	logic [1:0] eena_q;
	logic [1:0] eflag;
	logic line1_prev_q;
	logic line2_prev_q;
	logic line1_rise;
	logic line2_rise;
	logic [DW-1:0] pflag [NUM_PREG];
	logic [DW-1:0] pena_q [NUM_PREG];
	logic [DW-1:0] pprio_q [NUM_PREG];
	logic [NSRC-1:0] pflag_flat;
	logic [NSRC-1:0] pena_flat;
	logic [NSRC-1:0] pprio_flat;
	logic req_high;
	logic req_low;
	logic irq_high_q;
	logic irq_low_q;
	logic sys_irq_q;
	logic [DW-1:0] evt_set;
	logic [DW-1:0] evt_stat;
	logic [DW-1:0] evt_mask_q;
	logic [DW-1:0] rd_mux;
	logic [DW-1:0] rd_data_q;

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	assign addr = bus_req.addr;
	assign wdata = bus_req.wdata;
	assign wr = bus_req.wr;
	assign rd = bus_req.rd;
	assign wr_rst = wr && (addr == ADDR_RESET_CTRL);
	assign wr_ictl = wr && (addr == ADDR_INT_CTRL);
	assign wr_ext = wr && (addr == ADDR_EXT_CTRL);
	assign wr_emask = wr && (addr == ADDR_EVT_MASK);
	assign rd_stat = rd && (addr == ADDR_EVT_STAT);

	// ----------------------------------------------------------------
	// Global control bits
	// ----------------------------------------------------------------
	// priority mode switch
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ple_q <= 1'b0;
		end
		else if (wr_rst)
		begin
			ple_q <= wdata[PLE_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ghe_q <= 1'b0;
			plge_q <= 1'b0;
		end
		else if (wr_ictl)
		begin
			ghe_q <= wdata[GHE_BIT];
			plge_q <= wdata[PLGE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// External lines
	// ----------------------------------------------------------------
	// priority and enable bits
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			eprio_q <= {EXT_PRIO_RST, EXT_PRIO_RST};
			eena_q <= 2'b00;
		end
		else if (wr_ext)
		begin
			eprio_q <= {wdata[E2P_BIT], wdata[E1P_BIT]};
			eena_q <= {wdata[E2E_BIT], wdata[E1E_BIT]};
		end
	end

	// Rising edge detect; lines are taken as already synchronous
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			line1_prev_q <= 1'b0;
			line2_prev_q <= 1'b0;
		end
		else
		begin
			line1_prev_q <= ext_irq_line_one;
			line2_prev_q <= ext_irq_line_two;
		end
	end

	assign line1_rise = ext_irq_line_one & ~line1_prev_q;
	assign line2_rise = ext_irq_line_two & ~line2_prev_q;

	ifep_flag_bank #(
		.W(2)
	) u_ext_flags (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.hw_set({line2_rise, line1_rise}),
		.sw_wr(wr_ext),
		.sw_data({wdata[E2F_BIT], wdata[E1F_BIT]}),
		.sw_mask(2'b11),
		.flags(eflag)
	);

	// ----------------------------------------------------------------
	// Peripheral banks
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_PREG; i++)
	begin : g_preg
		ifep_flag_bank #(
			.W(DW)
		) u_pflags (
			.clk_sys(clk_sys),
			.arst_n(arst_n),
			.hw_set(periph_event[i*DW +: DW]),
			.sw_wr(wr && (addr == ADDR_FLAG_BASE + AW'(i))),
			.sw_data(wdata),
			.sw_mask({DW{1'b1}}),
			.flags(pflag[i])
		);

		always_ff @(posedge clk_sys or negedge arst_n)
		begin
			if (!arst_n)
			begin
				pena_q[i] <= ZERO_RST;
			end
			else if (wr && (addr == ADDR_ENA_BASE + AW'(i)))
			begin
				pena_q[i] <= wdata;
			end
		end

		always_ff @(posedge clk_sys or negedge arst_n)
		begin
			if (!arst_n)
			begin
				pprio_q[i] <= PRIO_RST;
			end
			else if (wr && (addr == ADDR_PRIO_BASE + AW'(i)))
			begin
				pprio_q[i] <= wdata;
			end
		end

		assign pflag_flat[i*DW +: DW] = pflag[i];
		assign pena_flat[i*DW +: DW] = pena_q[i];
		assign pprio_flat[i*DW +: DW] = pprio_q[i];
	end

	// ----------------------------------------------------------------
	// Request routing
	// ----------------------------------------------------------------
	ifep_req_router #(
		.N(NSRC)
	) u_router (
		.pflag(pflag_flat),
		.pena(pena_flat),
		.pprio(pprio_flat),
		.eflag(eflag),
		.eena(eena_q),
		.eprio(eprio_q),
		.ple(ple_q),
		.ghe(ghe_q),
		.plge(plge_q),
		.req_high(req_high),
		.req_low(req_low)
	);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_high_q <= 1'b0;
			irq_low_q <= 1'b0;
		end
		else
		begin
			irq_high_q <= req_high;
			irq_low_q <= req_low;
		end
	end

	// ----------------------------------------------------------------
	// Event status and mask
	// ----------------------------------------------------------------
	always_comb
	begin
		evt_set = '0;
		evt_set[EV_HIGH] = req_high & ~irq_high_q;
		evt_set[EV_LOW] = req_low & ~irq_low_q;
		evt_set[EV_LINE1] = line1_rise;
		evt_set[EV_LINE2] = line2_rise;
	end

	// Cleared by its own read; a new event in that cycle survives
	ifep_flag_bank #(
		.W(DW)
	) u_evt_stat (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.hw_set(evt_set),
		.sw_wr(rd_stat),
		.sw_data({DW{1'b0}}),
		.sw_mask({DW{1'b1}}),
		.flags(evt_stat)
	);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			evt_mask_q <= ZERO_RST;
		end
		else if (wr_emask)
		begin
			evt_mask_q <= wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sys_irq_q <= 1'b0;
		end
		else
		begin
			sys_irq_q <= |(evt_stat & evt_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// every control register reads back
	always_comb
	begin
		rd_mux = '0;
		if (addr == ADDR_RESET_CTRL)
		begin
			rd_mux[PLE_BIT] = ple_q;
		end
		else if (addr == ADDR_INT_CTRL)
		begin
			rd_mux[GHE_BIT] = ghe_q;
			rd_mux[PLGE_BIT] = plge_q;
		end
		else if (addr == ADDR_EXT_CTRL)
		begin
			rd_mux[E2P_BIT] = eprio_q[1];
			rd_mux[E1P_BIT] = eprio_q[0];
			rd_mux[E2E_BIT] = eena_q[1];
			rd_mux[E1E_BIT] = eena_q[0];
			rd_mux[E2F_BIT] = eflag[1];
			rd_mux[E1F_BIT] = eflag[0];
		end
		else if (ifep_in_bank(addr, ADDR_FLAG_BASE, NUM_PREG))
		begin
			rd_mux = pflag[addr[2:0]];
		end
		else if (ifep_in_bank(addr, ADDR_ENA_BASE, NUM_PREG))
		begin
			rd_mux = pena_q[addr[2:0]];
		end
		else if (ifep_in_bank(addr, ADDR_PRIO_BASE, NUM_PREG))
		begin
			rd_mux = pprio_q[addr[2:0]];
		end
		else if (addr == ADDR_EVT_STAT)
		begin
			rd_mux = evt_stat;
		end
		else if (addr == ADDR_EVT_MASK)
		begin
			rd_mux = evt_mask_q;
		end
	end

	// Data stand one cycle only; zero otherwise and for unmapped reads
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data_q <= ZERO_RST;
		end
		else
		begin
			rd_data_q <= rd ? rd_mux : ZERO_RST;
		end
	end

	assign rd_data = rd_data_q;
	assign irq_high = irq_high_q;
	assign irq_low = irq_low_q;
	assign sys_irq = sys_irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	AST_PLE_WRITE: assert property (
		wr_rst |=> ple_q == $past(wdata[PLE_BIT]))
		else $error("priority mode bit not written");

	AST_EXT_READBACK: assert property (
		wr_ext && !line1_rise && !line2_rise ##1 !wr_ext && !line1_rise && !line2_rise
		##1 rd && addr == ADDR_EXT_CTRL
		|=> rd_data == ($past(wdata, 3) & 8'hDB))
		else $error("external control readback wrong");

	AST_PFLAG_SET: assert property (
		periph_event[0] |=> pflag[0][0] ##1 pflag[0][0] || $past(wr, 1))
		else $error("peripheral flag not set");

	AST_PENA_WRITE: assert property (
		wr && addr == ADDR_ENA_BASE |=> pena_q[0] == $past(wdata))
		else $error("enable register not written");

	AST_COMPAT_PERIPH: assert property (
		!ple_q && !plge_q && !(|(eflag & eena_q)) |=> !irq_high)
		else $error("peripheral request without peripheral enable");

	AST_PRIO_WRITE: assert property (
		wr && addr == ADDR_PRIO_BASE |=> pprio_q[0] == $past(wdata))
		else $error("priority register not written");

	AST_NO_LOW_COMPAT: assert property (
		!ple_q |=> !irq_low)
		else $error("low request in single-level mode");

	AST_FLAG_UNGATED: assert property (
		line1_rise && !eena_q[0] |=> eflag[0])
		else $error("flag blocked by enable");

	AST_EXT_CLEAR: assert property (
		wr_ext && !wdata[E1F_BIT] && !line1_rise |=> !eflag[0])
		else $error("external flag not cleared");

	AST_REQ_CAUSE: assert property (
		irq_high |-> $past(ghe_q) && $past(|(pflag_flat & pena_flat) || |(eflag & eena_q)))
		else $error("request without flag, enable and global enable");

	AST_LOW_ROUTE: assert property (
		ple_q && ghe_q && plge_q && |(eflag & eena_q & ~eprio_q)
		|=> irq_low)
		else $error("low priority source not routed low");

	AST_SYS_IRQ: assert property (
		(|(evt_stat & evt_mask_q)) |=> sys_irq)
		else $error("masked status not raising interrupt");
endmodule // ifep_top
`default_nettype wire

// file: verif/ifep_core_model.sv
/*
	Behavioural processor core: latches each request level it sees.
	Assumes irq_high and irq_low are registered levels on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module ifep_core_model
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic irq_high,
	input wire logic irq_low,
	input wire logic ack,
	output logic took_high_q,
	output logic took_low_q
);
	// Sticky until acked, so a one-cycle request is lost only in a cycle with ack
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			took_high_q <= 1'b0;
			took_low_q <= 1'b0;
		end
		else if (ack)
		begin
			took_high_q <= 1'b0;
			took_low_q <= 1'b0;
		end
		else
		begin
			took_high_q <= took_high_q | irq_high;
			took_low_q <= took_low_q | irq_low;
		end
	end
endmodule // ifep_core_model
`default_nettype wire

// file: verif/tb_interrupt_flag_enable_priority.sv
/*
	Self-checking bench for ifep_top: register port tasks and scenarios.
	Assumes a 200 MHz clock and the core model on the request outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_flag_enable_priority;
	import ifep_pkg::*;
	logic clk_sys;
	logic arst_n;
	ifep_bus_req_t bus_req;
	logic [DW-1:0] rd_data;
	logic [5*DW-1:0] periph_event;
	logic line_one;
	logic line_two;
	logic irq_high;
	logic irq_low;
	logic sys_irq;
	logic ack;
	logic took_high_q;
	logic took_low_q;
	logic [7:0] rv;
	int bad_count;
	int cmp_count;
	logic [7:0] ra [8] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h10, 8'h18, 8'h20, 8'h05};
	logic [7:0] re [8] = '{8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};

	ifep_top #(.NUM_PREG(5)) ifep_top_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.bus_req(bus_req), .rd_data(rd_data), .periph_event(periph_event),
		.ext_irq_line_one(line_one), .ext_irq_line_two(line_two),
		.irq_high(irq_high), .irq_low(irq_low), .sys_irq(sys_irq));
	ifep_core_model ifep_core_model_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.irq_high(irq_high), .irq_low(irq_low), .ack(ack),
		.took_high_q(took_high_q), .took_low_q(took_low_q));

	// ----------------------------------------------------------------
	// Clock, tasks
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 d = rd_data;
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		rd(a, rv);
		chk(name, rv, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic pulse_ev(input int idx);
		@(posedge clk_sys);
		periph_event[idx] <= 1'b1;
		@(posedge clk_sys);
		periph_event <= '0;
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#(20000 * 5);
		bad_count++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		arst_n = 1'b0;
		bus_req = '0;
		periph_event = '0;
		line_one = 1'b0;
		line_two = 1'b0;
		ack = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rchk("reset value", ra[i], re[i]);
		// Reserved bits read 0, flags writable by software
		wr(8'h02, 8'hFF);
		rchk("ext control", 8'h02, 8'hDB);
		idle(2);
		chk("high no global", {7'h00, irq_high}, 8'h00);
		wr(8'h02, 8'hC0);
		// Flags set with every enable off, in the first and fifth register
		pulse_ev(0);
		pulse_ev(4 * 8 + 7);
		rchk("flag reg0", 8'h08, 8'h01);
		rchk("flag reg4", 8'h0C, 8'h80);
		chk("high disabled", {7'h00, irq_high}, 8'h00);
		wr(8'h0C, 8'h00);
		wr(8'h14, 8'hA5);
		rchk("enable reg4", 8'h14, 8'hA5);
		wr(8'h14, 8'h00);
		// Single level needs the peripheral global enable
		wr(8'h10, 8'h01);
		wr(8'h01, 8'h80);
		idle(3);
		chk("high no periph", {7'h00, irq_high}, 8'h00);
		wr(8'h01, 8'hC0);
		idle(3);
		chk("high single", {irq_low, irq_high}, 8'h01);
		chk("core took high", {7'h00, took_high_q}, 8'h01);
		// Priority mode: route by the priority bit
		wr(8'h00, 8'h80);
		rchk("priority enable", 8'h00, 8'h80);
		wr(8'h18, 8'h00);
		rchk("priority reg0", 8'h18, 8'h00);
		idle(3);
		chk("low routed", {irq_low, irq_high}, 8'h02);
		chk("core took low", {7'h00, took_low_q}, 8'h01);
		wr(8'h18, 8'h01);
		idle(3);
		chk("high routed", {irq_low, irq_high}, 8'h01);
		wr(8'h18, 8'h00);
		wr(8'h00, 8'h00);
		idle(3);
		chk("prio ignored", {irq_low, irq_high}, 8'h01);
		wr(8'h08, 8'h00);
		idle(3);
		chk("flag cleared", {irq_low, irq_high}, 8'h00);
		// Acknowledge drops what the core latched, no request left behind
		@(posedge clk_sys);
		ack <= 1'b1;
		@(posedge clk_sys);
		ack <= 1'b0;
		idle(1);
		chk("core ack", {6'h00, took_low_q, took_high_q}, 8'h00);
		// Line one edge: flag and masked status interrupt
		wr(8'h21, 8'h04);
		rd(8'h20, rv);
		@(posedge clk_sys);
		line_one <= 1'b1;
		@(posedge clk_sys);
		line_one <= 1'b0;
		idle(3);
		chk("status irq", {7'h00, sys_irq}, 8'h01);
		rchk("line one flag", 8'h02, 8'hC1);
		rchk("status", 8'h20, 8'h04);
		idle(3);
		chk("status cleared", {7'h00, sys_irq}, 8'h00);
		// Line two at low priority in priority mode
		wr(8'h02, 8'h50);
		wr(8'h00, 8'h80);
		@(posedge clk_sys);
		line_two <= 1'b1;
		idle(4);
		chk("line two low", {irq_low, irq_high}, 8'h02);
		rchk("line two flag", 8'h02, 8'h52);
		conclude();
	end
endmodule // tb_interrupt_flag_enable_priority
`default_nettype wire
